// [verilog/adcfp_pkg.sv]
// shared constants for the converter output path
package adcfp_pkg;
  // ---------------------------------------------------------------
  // data layout
  // ---------------------------------------------------------------
  localparam int RES_W   = 16;
  localparam int WORD_W  = 18;
  localparam int DEPTH   = 16;
  localparam int CNT_W   = 5;
  localparam int HALF    = 8;
  localparam int BIT_MSBN = 16;
  localparam int BIT_OVF  = 17;
  // ---------------------------------------------------------------
  // fill status codes {high, low}
  // ---------------------------------------------------------------
  localparam logic [1:0] STAT_EMPTY = 2'h1;
  localparam logic [1:0] STAT_LOW   = 2'h0;
  localparam logic [1:0] STAT_HALF  = 2'h2;
  localparam logic [1:0] STAT_FULL  = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int SWITCH_NS   = 20;
  localparam int SWITCH_CYC  = (SWITCH_NS / CLK_NS < 1) ? 1 : SWITCH_NS / CLK_NS;
  localparam int CONV_NS     = 300;
  localparam int CONV_CYC    = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIPE_STAGES = 3;
  localparam int START_HI_NS = 100;
  localparam int START_HI_CYC = (START_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS      = 500;
  localparam int GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_HI_CYC   = 2;
  localparam int RD_LO_CYC   = 2;
endpackage

// [verilog/adcfp_if.sv]
// pin-level link between converter output path and host
`timescale 1ns/1ps
`default_nettype none
interface adcfp_if;
  logic        start_conv;
  logic        eoc;
  logic        fifo_sel;
  logic        rd_strobe;
  logic        out_en_n;
  logic        coding_sel;
  logic [15:0] data_out;
  logic        data_oe;
  logic        msb_n;
  logic        overflow;
  logic        fill_status_high_bit;
  logic        fill_status_low_bit;
  modport dev (
    input  start_conv, fifo_sel, rd_strobe, out_en_n, coding_sel,
    output eoc, data_out, data_oe, msb_n, overflow,
    output fill_status_high_bit, fill_status_low_bit
  );
  modport host (
    output start_conv, fifo_sel, rd_strobe, out_en_n, coding_sel,
    input  eoc, data_out, data_oe, msb_n, overflow,
    input  fill_status_high_bit, fill_status_low_bit
  );
endinterface
`default_nettype wire

// [verilog/adcfp_dev.sv]
// converter output path: result pipeline, fifo, coding and output stage
`timescale 1ns/1ps
`default_nettype none
module adcfp_dev
  import adcfp_pkg::*;
#(
  parameter int P_CONV_CYC = CONV_CYC
) (
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST_N,
  // pins toward host
  adcfp_if.dev                   LINK,
  // analog stand-in: sampled result and range flag
  input  wire logic [RES_W-1:0]  I_SAMPLE,
  input  wire logic              I_SAMPLE_OVR,
  // status
  output logic                   O_RESULT_INVALID
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       rd_d_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      meta_r <= 5'h1C;
      sync_r <= 5'h1C;
      rd_d_r <= 1'b1;
    end else begin
      meta_r <= {LINK.coding_sel, LINK.out_en_n, LINK.rd_strobe,
                 LINK.fifo_sel, LINK.start_conv};
      sync_r <= meta_r;
      rd_d_r <= sync_r[2];
    end
  end
  wire start_s  = sync_r[0];
  wire sel_s    = sync_r[1];
  wire rd_s     = sync_r[2];
  wire oen_s    = sync_r[3];
  // pull-up modelled by reset value of the synchroniser
  wire coding_s = sync_r[4];
  wire rd_rise  = rd_s & ~rd_d_r;
  wire rd_fall  = ~rd_s & rd_d_r;
  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  logic        start_d_r;
  logic        busy_r;
  logic [15:0] conv_cnt_r;
  logic        invalid_r;
  logic        bad_r;
  logic [WORD_W-1:0] pipe_r [PIPE_STAGES];
  logic [PIPE_STAGES-1:0] pbad_r;
  wire start_rise = start_s & ~start_d_r;
  wire conv_done  = busy_r && conv_cnt_r == 16'(P_CONV_CYC - 1);
  wire eoc_fall   = conv_done;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      start_d_r  <= 1'b0;
      busy_r     <= 1'b0;
      conv_cnt_r <= 16'h0000;
      bad_r      <= 1'b0;
      pbad_r     <= '1;
    end else begin
      start_d_r <= start_s;
      if (start_rise) begin
        busy_r     <= 1'b1;
        conv_cnt_r <= 16'h0000;
        bad_r      <= busy_r;
      end else if (conv_done) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        conv_cnt_r <= conv_cnt_r + 16'h0001;
      end
      if (start_rise)
        pbad_r <= {pbad_r[PIPE_STAGES-2:0], bad_r | busy_r};
    end
  end
  // result pipeline, one stage per finished conversion
  // the word leaving at a finish is three conversions old, so the
  // first real result needs four start pulses
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      for (int i = 0; i < PIPE_STAGES; i++)
        pipe_r[i] <= '0;
    end else if (conv_done) begin
      pipe_r[0] <= {I_SAMPLE_OVR, ~I_SAMPLE[RES_W-1], I_SAMPLE};
      for (int i = 1; i < PIPE_STAGES; i++)
        pipe_r[i] <= pipe_r[i-1];
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N)
      invalid_r <= 1'b1;
    else if (eoc_fall)
      invalid_r <= pbad_r[PIPE_STAGES-1];
  end
  wire [WORD_W-1:0] result = pipe_r[PIPE_STAGES-1];
  // ---------------------------------------------------------------
  // fifo
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem_r [DEPTH];
  logic [3:0]        wp_r;
  logic [3:0]        rp_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [WORD_W-1:0] head_r;
  logic [WORD_W-1:0] direct_r;
  logic [1:0]        stat_r;
  wire fifo_clr = ~sel_s & ~rd_s;
  // direct mode ignores write and read
  wire do_wr    = sel_s & eoc_fall & (cnt_r != CNT_W'(DEPTH));
  wire do_rd    = sel_s & rd_rise & (cnt_r > CNT_W'(1));
  wire last_out = sel_s & rd_fall & (cnt_r == CNT_W'(1));
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      wp_r  <= 4'h0;
      rp_r  <= 4'h0;
      cnt_r <= '0;
    end else if (fifo_clr) begin
      wp_r  <= 4'h0;
      rp_r  <= 4'h0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        mem_r[wp_r] <= result;
        wp_r        <= wp_r + 4'h1;
      end
      if (do_rd)
        rp_r <= rp_r + 4'h1;
      if (last_out)
        rp_r <= rp_r + 4'h1;
      cnt_r <= cnt_r + CNT_W'(do_wr) - CNT_W'(do_rd) - CNT_W'(last_out);
    end
  end
  // head word stays on output until read; kept when fifo drains
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      head_r <= '0;
    end else if (do_wr && cnt_r == '0) begin
      head_r <= result;
    end else if (do_rd) begin
      head_r <= mem_r[rp_r + 4'h1];
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N)
      direct_r <= '0;
    else if (eoc_fall)
      direct_r <= result;
  end
  // status in one cycle after each change
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N)
      stat_r <= STAT_EMPTY;
    else if (cnt_r == CNT_W'(DEPTH))
      stat_r <= STAT_FULL;
    else if (cnt_r >= CNT_W'(HALF))
      stat_r <= STAT_HALF;
    else if (cnt_r != '0)
      stat_r <= STAT_LOW;
    else
      stat_r <= STAT_EMPTY;
  end
  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  // path select switches within the synchroniser delay (20 ns worst);
  // tighter than pin pacing allows at this clock
  wire [WORD_W-1:0] path = sel_s ? head_r : direct_r;
  wire [WORD_W-1:0] coded = coding_s ? path
                            : {path[BIT_OVF], ~path[BIT_MSBN:0]};
  // overflow retains its raw meaning; inversion swaps which end set it
  logic [RES_W-1:0] dout_r;
  logic             msbn_r;
  logic             ovf_r;
  logic             oe_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      dout_r <= '0;
      msbn_r <= 1'b0;
      ovf_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      dout_r <= coded[RES_W-1:0];
      msbn_r <= coded[BIT_MSBN];
      ovf_r  <= coded[BIT_OVF];
      oe_r   <= ~oen_s;
    end
  end
  assign LINK.eoc      = busy_r;
  assign LINK.data_out = dout_r;
  assign LINK.data_oe  = oe_r;
  assign LINK.msb_n    = msbn_r;
  assign LINK.overflow = ovf_r;
  assign LINK.fill_status_high_bit = stat_r[1];
  assign LINK.fill_status_low_bit  = stat_r[0];
  assign O_RESULT_INVALID = invalid_r;
endmodule
`default_nettype wire

// [verilog/adcfp_host.sv]
// host end: paces conversions and reads the buffer
`timescale 1ns/1ps
`default_nettype none
module adcfp_host
  import adcfp_pkg::*;
(
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST_N,
  // pins toward converter
  adcfp_if.host                  LINK,
  // user controls
  input  wire logic              I_RUN,
  input  wire logic              I_FIFO_MODE,
  input  wire logic              I_CODING,
  input  wire logic              I_OUT_EN,
  input  wire logic              I_READ_REQ,
  input  wire logic              I_CLEAR_REQ,
  // user status
  output logic [RES_W-1:0]       O_DATA,
  output logic                   O_DATA_VALID,
  output logic [1:0]             O_FILL
);
  // ---------------------------------------------------------------
  // synchronise converter pins
  // ---------------------------------------------------------------
  logic [18:0] meta_r;
  logic [18:0] sync_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {LINK.fill_status_high_bit, LINK.fill_status_low_bit,
                 LINK.eoc, LINK.data_out};
      sync_r <= meta_r;
    end
  end
  wire eoc_s = sync_r[16];
  // ---------------------------------------------------------------
  // start pulse train: 100 ns high, in band
  // ---------------------------------------------------------------
  logic [7:0] tmr_r;
  logic       start_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      tmr_r   <= 8'h00;
      start_r <= 1'b0;
    end else if (!I_RUN) begin
      tmr_r   <= 8'h00;
      start_r <= 1'b0;
    end else if (tmr_r == 8'(GAP_CYC - 1)) begin
      tmr_r   <= 8'h00;
      start_r <= ~eoc_s;
    end else begin
      tmr_r <= tmr_r + 8'h01;
      if (tmr_r == 8'(START_HI_CYC - 1))
        start_r <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // read strobe: low then rising edge, only outside conversion
  // ---------------------------------------------------------------
  logic       rd_r;
  logic [2:0] rdc_r;
  logic       mode_r;
  logic       code_r;
  logic       oen_r;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rd_r   <= 1'b1;
      rdc_r  <= 3'h0;
      mode_r <= 1'b0;
      code_r <= 1'b1;
      oen_r  <= 1'b1;
    end else begin
      if (!eoc_s) begin
        mode_r <= I_FIFO_MODE;
        code_r <= I_CODING;
        oen_r  <= ~I_OUT_EN;
      end
      if (rdc_r != 3'h0) begin
        rdc_r <= rdc_r - 3'h1;
        if (rdc_r == 3'(RD_HI_CYC))
          rd_r <= 1'b1;
      end else if (I_CLEAR_REQ && !eoc_s) begin
        rd_r <= 1'b0;
      end else if (I_READ_REQ && !eoc_s) begin
        rd_r  <= 1'b0;
        rdc_r <= 3'(RD_LO_CYC + RD_HI_CYC);
      end else begin
        rd_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_DATA       <= '0;
      O_DATA_VALID <= 1'b0;
      O_FILL       <= STAT_EMPTY;
    end else begin
      O_DATA       <= sync_r[15:0];
      O_DATA_VALID <= ~eoc_s & ~oen_r;
      O_FILL       <= sync_r[18:17];
    end
  end
  assign LINK.start_conv = start_r;
  assign LINK.rd_strobe  = rd_r;
  assign LINK.fifo_sel   = I_CLEAR_REQ ? 1'b0 : mode_r;
  assign LINK.coding_sel = code_r;
  assign LINK.out_en_n   = oen_r;
endmodule
`default_nettype wire

// [bench/adcfp_properties.sv]
// pin-level checks between the converter output path and its host
`timescale 1ns/1ps
`default_nettype none
module adcfp_properties
  import adcfp_pkg::*;
(
  // clock and reset
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST_N,
  // link pins
  input wire logic        start_conv,
  input wire logic        eoc,
  input wire logic        fifo_sel,
  input wire logic        rd_strobe,
  input wire logic        out_en_n,
  input wire logic        coding_sel,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        msb_n,
  input wire logic        overflow,
  input wire logic        fill_status_high_bit,
  input wire logic        fill_status_low_bit
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [1:0] st;
  logic       fall;
  logic       eoc_d_r;
  logic [7:0] since_r;
  logic [2:0] falls_r;
  assign st   = {fill_status_high_bit, fill_status_low_bit};
  assign fall = eoc_d_r && !eoc;
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      eoc_d_r <= 1'b0;
      since_r <= 8'hFF;
      falls_r <= 3'h0;
    end else begin
      eoc_d_r <= eoc;
      since_r <= fall ? 8'h00 : since_r + {7'h0, since_r != 8'hFF};
      falls_r <= falls_r + {2'h0, fall && falls_r != 3'h7};
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  property p_oe;
    $stable(out_en_n) [*5] |-> data_oe == !out_en_n;
  endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_clear;
    (!fifo_sel && !rd_strobe) [*6] |-> st == STAT_EMPTY;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_direct;
    (!fifo_sel && rd_strobe) [*6] |=> $stable(st);
  endproperty
  a_direct: assert property (p_direct) else $error("direct moved");
  property p_first;
    fifo_sel [*6] ##0 (fall && st == STAT_EMPTY && rd_strobe)
      |-> ##[1:19] st == STAT_LOW;
  endproperty
  a_first: assert property (p_first) else $error("no write");
  property p_one;
    $past(st) == STAT_EMPTY && st != STAT_EMPTY |-> st == STAT_LOW;
  endproperty
  a_one: assert property (p_one) else $error("bad step");
  property p_full;
    $past(st) == STAT_HALF && st == STAT_FULL |-> since_r <= 8'h03;
  endproperty
  a_full: assert property (p_full) else $error("late full");
  property p_keep;
    rd_strobe [*6] ##0 st == STAT_FULL |=> st == STAT_FULL;
  endproperty
  a_keep: assert property (p_keep) else $error("full lost");
  // pipeline slots before the fourth result hold reset words;
  // an empty buffer that was never written shows its reset word
  property p_msb;
    data_oe && falls_r >= 3'h5 && $stable(data_out) && $stable(msb_n)
      && (!fifo_sel || st != STAT_EMPTY) |-> msb_n != data_out[15];
  endproperty
  a_msb: assert property (p_msb) else $error("msb pair");
  c_full: cover property (st == STAT_FULL);
  c_clear: cover property ((!fifo_sel && !rd_strobe) [*6]);
  c_inv: cover property (data_oe && !coding_sel && overflow);
  c_start: cover property ($rose(start_conv));
endmodule
`default_nettype wire

// [bench/adc_output_fifo_path_test.sv]
// self-checking bench joining the converter path to its host
`timescale 1ns/1ps
`default_nettype none
module adc_output_fifo_path_test;
  import adcfp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        run = 1'b0;
  logic        fifo_mode = 1'b0;
  logic        coding = 1'b1;
  logic        out_en = 1'b0;
  logic        read_req = 1'b0;
  logic        clear_req = 1'b0;
  logic        step_en = 1'b0;
  logic        eoc_q = 1'b0;
  logic        ovr = 1'b0;
  logic [15:0] sample = 16'h1234;
  logic        res_bad;
  logic [15:0] h_data;
  logic        h_valid;
  logic [1:0]  h_fill;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  adcfp_if link ();
  // conversion cut to 5 cycles to keep the run short
  adcfp_dev #(.P_CONV_CYC(5)) adcfp_dev_inst (
    .I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .LINK(link),
    .I_SAMPLE(sample), .I_SAMPLE_OVR(ovr), .O_RESULT_INVALID(res_bad));
  adcfp_host adcfp_host_inst (
    .I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .LINK(link), .I_RUN(run),
    .I_FIFO_MODE(fifo_mode), .I_CODING(coding), .I_OUT_EN(out_en),
    .I_READ_REQ(read_req), .I_CLEAR_REQ(clear_req), .O_DATA(h_data),
    .O_DATA_VALID(h_valid), .O_FILL(h_fill));
  adcfp_properties adcfp_properties_inst (
    .I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .start_conv(link.start_conv),
    .eoc(link.eoc), .fifo_sel(link.fifo_sel), .rd_strobe(link.rd_strobe),
    .out_en_n(link.out_en_n), .coding_sel(link.coding_sel),
    .data_out(link.data_out), .data_oe(link.data_oe), .msb_n(link.msb_n),
    .overflow(link.overflow),
    .fill_status_high_bit(link.fill_status_high_bit),
    .fill_status_low_bit(link.fill_status_low_bit));
  always #5 clk_sys = ~clk_sys;
  // one new sample per conversion, so buffered words count up by one
  always @(posedge clk_sys) begin
    eoc_q <= link.eoc;
    cycles <= cycles + 1;
    if (step_en && link.eoc && !eoc_q) begin
      sample <= sample + 16'h0001;
    end
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] fill_st();
    return {link.fill_status_high_bit, link.fill_status_low_bit};
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_fill(input logic [1:0] want);
    int n;
    n = 0;
    while (fill_st() !== want && n < 2000) begin
      cyc(1);
      n++;
    end
    check("fill", 16'(fill_st()), 16'(want));
  endtask
  task automatic rd_one();
    @(posedge clk_sys) read_req <= 1'b1;
    @(posedge clk_sys) read_req <= 1'b0;
    cyc(12);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_direct();
    @(posedge clk_sys);
    out_en <= 1'b1;
    run <= 1'b1;
    cyc(300);
    check("data", link.data_out, 16'h1234);
    check("msb", 16'(link.msb_n), 16'h0001);
    check("oe", 16'(link.data_oe), 16'h0001);
    check("host data", h_data, 16'h1234);
    check("invalid", 16'(res_bad), 16'h0000);
    @(posedge clk_sys);
    coding <= 1'b0;
    ovr <= 1'b1;
    cyc(300);
    check("inv data", link.data_out, 16'hEDCB);
    check("inv msb", 16'(link.msb_n), 16'h0000);
    check("ovf", 16'(link.overflow), 16'h0001);
    @(posedge clk_sys) out_en <= 1'b0;
    cyc(20);
    check("oe off", 16'(link.data_oe), 16'h0000);
    check("host valid", 16'(h_valid), 16'h0000);
    @(posedge clk_sys);
    out_en <= 1'b1;
    coding <= 1'b1;
    ovr <= 1'b0;
    $display("test direct done");
  endtask
  task automatic test_fill();
    logic [15:0] first;
    @(posedge clk_sys) step_en <= 1'b1;
    // flush the repeated words out of the pipeline first
    cyc(300);
    @(posedge clk_sys) fifo_mode <= 1'b1;
    wait_fill(STAT_LOW);
    cyc(3);
    first = link.data_out;
    wait_fill(STAT_HALF);
    wait_fill(STAT_FULL);
    cyc(120);
    check("full", 16'(fill_st()), 16'(STAT_FULL));
    check("host fill", 16'(h_fill), 16'(STAT_FULL));
    check("head", link.data_out, first);
    @(posedge clk_sys);
    run <= 1'b0;
    step_en <= 1'b0;
    cyc(60);
    for (int i = 1; i < 16; i++) begin
      rd_one();
      check("word", link.data_out, first + 16'(i));
    end
    check("one left", 16'(fill_st()), 16'(STAT_LOW));
    rd_one();
    check("empty", 16'(fill_st()), 16'(STAT_EMPTY));
    check("kept", link.data_out, first + 16'h000F);
    rd_one();
    check("kept2", link.data_out, first + 16'h000F);
    $display("test fill done");
  endtask
  task automatic test_clear();
    @(posedge clk_sys) run <= 1'b1;
    wait_fill(STAT_LOW);
    // conversions keep running so direct mode sees finishes it must not write
    @(posedge clk_sys) fifo_mode <= 1'b0;
    cyc(200);
    check("direct keep", 16'(fill_st()), 16'(STAT_LOW));
    @(posedge clk_sys) run <= 1'b0;
    cyc(60);
    @(posedge clk_sys) clear_req <= 1'b1;
    cyc(10);
    check("cleared", 16'(fill_st()), 16'(STAT_EMPTY));
    @(posedge clk_sys);
    clear_req <= 1'b0;
    run <= 1'b1;
    cyc(200);
    check("no write", 16'(fill_st()), 16'(STAT_EMPTY));
    $display("test clear done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(4);
    test_direct();
    test_fill();
    test_clear();
    test_done();
  end
endmodule
`default_nettype wire
